// *** src/pocd_defines.vh ***
// Contract
// - Command register is write-only, 32 bits wide, at register offset 7C.
// - Command contents stay frozen from operation start until it finishes.
// - Byte lanes map little- or big-endian per selected interface byte order.
// - Writing the most significant byte starts operations, except draw-and-step and line draw.
// - Draw-and-step and line draw start only on direction-steps register write.
// - Byte 3 bits 7-6: background source; 00 colour, 10 source map.
// - Byte 3 bits 5-4: foreground source; 00 colour, 10 source map.
// - Byte 3 bits 3-0 function: 2,3,4,5 step/line read/write codes.
// - Function codes 8,9,A are block transfers; others listed are reserved.
// - Byte 2 bits 7-4 select source map A, B or C.
// - Byte 2 bits 3-0 select destination map A, B or C.
// - Byte 1 bits 7-4 select pattern map A, B or C.
// - Pattern code 1000 forces every pattern pixel to one, foreground mix.
// - Pattern code 1001 derives pattern from source: nonzero means foreground.
// - Byte 0 bits 7-6 mask map mode: off, boundary, enabled, reserved.
// - Byte 0 bits 5-4 draw style: all, first null, last null, boundary.
// - Byte 0 bits 2-0 are x direction, y direction and major axis bits.
// - Foreground colour register at 58 supplies colour, low depth bits only.
// - Background colour register at 5C supplies colour, low depth bits only.
`ifndef POCD_DEFINES_VH
`define POCD_DEFINES_VH

`define POCD_OFS_CMD       7'h7C
`define POCD_OFS_FG_COLOUR 7'h58
`define POCD_OFS_BG_COLOUR 7'h5C
`define POCD_OFS_DIR_STEPS 7'h2C

`define POCD_CMD_RESET     32'h00000000
`define POCD_COLOUR_RESET  32'h00000000

`define POCD_SRC_COLOUR    2'h0
`define POCD_SRC_MAP       2'h2

`define POCD_FN_DS_READ    4'h2
`define POCD_FN_LINE_READ  4'h3
`define POCD_FN_DS_WRITE   4'h4
`define POCD_FN_LINE_WRITE 4'h5
`define POCD_FN_BLT        4'h8
`define POCD_FN_INV_BLT    4'h9
`define POCD_FN_FILL_BLT   4'hA

`define POCD_MAP_A         4'h1
`define POCD_MAP_B         4'h2
`define POCD_MAP_C         4'h3
`define POCD_PAT_FIXED_FG  4'h8
`define POCD_PAT_FROM_SRC  4'h9

`define POCD_MSK_OFF       2'h0
`define POCD_MSK_BOUNDARY  2'h1
`define POCD_MSK_ON        2'h2

`define POCD_BS_MSB  31
`define POCD_FS_MSB  29
`define POCD_FN_MSB  27
`define POCD_SRC_MSB 23
`define POCD_DST_MSB 19
`define POCD_PAT_MSB 15
`define POCD_MSK_MSB 7
`define POCD_DM_MSB  5
`define POCD_DX_BIT  2
`define POCD_DY_BIT  1
`define POCD_DZ_BIT  0

`endif

// *** src/pocd_lane_map.v ***
`default_nettype none
// Maps bus byte lanes to command byte numbers for the selected byte order
module pocd_lane_map
(
  input  wire        big_endian_i,
  input  wire [31:0] wdata_i,
  input  wire [3:0]  be_i,
  output wire [31:0] data_o,
  output wire [3:0]  be_o
);

  assign data_o = big_endian_i ?
                  {wdata_i[7:0], wdata_i[15:8],
                   wdata_i[23:16], wdata_i[31:24]} : wdata_i;
  assign be_o   = big_endian_i ?
                  {be_i[0], be_i[1], be_i[2], be_i[3]} : be_i;

endmodule // pocd_lane_map
`default_nettype wire

// *** src/pocd_decoder.v ***
`include "pocd_defines.vh"
`default_nettype none
module pocd_decoder
#(
  parameter PIX_W = 32
)
(
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire             big_endian_i,
  input  wire             wr_i,
  input  wire [6:0]       addr_i,
  input  wire [31:0]      wdata_i,
  input  wire [3:0]       be_i,
  input  wire             op_done_i,
  input  wire [5:0]       dest_depth_i,
  input  wire             pattern_pixel_i,
  input  wire             source_nonzero_i,
  input  wire [PIX_W-1:0] source_pixel_i,
  output wire             wr_ready_o,
  output reg              op_start_o,
  output reg              busy_o,
  output reg  [1:0]       background_source_select_o,
  output reg  [1:0]       foreground_source_select_o,
  output reg  [3:0]       function_code_o,
  output reg              rectangle_block_transfer_o,
  output reg              inverting_block_transfer_o,
  output reg              area_fill_block_transfer_o,
  output reg              draw_and_step_o,
  output reg              line_draw_o,
  output reg              step_read_o,
  output reg              fn_reserved_o,
  output reg  [3:0]       source_map_o,
  output reg  [3:0]       dest_map_o,
  output reg  [3:0]       pattern_map_o,
  output reg              pattern_fixed_o,
  output reg              pattern_from_source_o,
  output reg  [1:0]       scissor_map_mode_o,
  output reg  [1:0]       draw_style_o,
  output reg              x_direction_bit_o,
  output reg              y_direction_bit_o,
  output reg              major_axis_bit_o,
  output wire             pattern_eff_o,
  output wire [PIX_W-1:0] mix_source_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  reg  [1:0]       state;
  reg  [31:0]      cmd;
  reg  [31:0]      fg_colour;
  reg  [31:0]      bg_colour;
  reg  [31:0]      next_cmd;
  reg              next_start;
  reg  [1:0]       next_state;
  reg  [PIX_W-1:0] depth_mask;
  reg  [PIX_W-1:0] colour_sel;
  wire [31:0]      lane_data;
  wire [3:0]       lane_be;
  wire             hit_cmd;
  wire             hit_fg;
  wire             hit_bg;
  wire             hit_steps;
  wire [3:0]       new_fn;
  wire             new_is_step;
  wire             cur_is_step;
  integer          i;
  integer          j;
  integer          k;

  pocd_lane_map u_lane_map
  (
    .big_endian_i (big_endian_i),
    .wdata_i      (wdata_i),
    .be_i         (be_i),
    .data_o       (lane_data),
    .be_o         (lane_be)
  );

  assign hit_cmd   = wr_i && (addr_i == `POCD_OFS_CMD);
  assign hit_fg    = wr_i && (addr_i == `POCD_OFS_FG_COLOUR);
  assign hit_bg    = wr_i && (addr_i == `POCD_OFS_BG_COLOUR);
  assign hit_steps = wr_i && (addr_i == `POCD_OFS_DIR_STEPS);

  // Ready is low while an operation runs; command writes are dropped so the command stays frozen
  assign wr_ready_o = (state == ST_IDLE);

  always @*
  begin
    next_cmd = cmd;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (lane_be[i])
      begin
        next_cmd[i*8 +: 8] = lane_data[i*8 +: 8];
      end
    end
  end

  assign new_fn      = next_cmd[`POCD_FN_MSB -: 4];
  assign new_is_step = (new_fn == `POCD_FN_DS_READ) ||
                       (new_fn == `POCD_FN_LINE_READ) ||
                       (new_fn == `POCD_FN_DS_WRITE) ||
                       (new_fn == `POCD_FN_LINE_WRITE);
  // A steps write carries no command bytes, so judge the stored function
  assign cur_is_step = (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_DS_READ) ||
                       (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_LINE_READ) ||
                       (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_DS_WRITE) ||
                       (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_LINE_WRITE);

  always @*
  begin
    next_start = 1'b0;
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (hit_cmd && lane_be[3] && !new_is_step)
        begin
          next_start = 1'b1;
        end
        if (hit_steps && cur_is_step)
        begin
          next_start = 1'b1;
        end
        if (next_start)
        begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        if (op_done_i)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state      <= ST_IDLE;
      cmd        <= `POCD_CMD_RESET;
      fg_colour  <= `POCD_COLOUR_RESET;
      bg_colour  <= `POCD_COLOUR_RESET;
      op_start_o <= 1'b0;
      busy_o     <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      op_start_o <= next_start;
      busy_o     <= (next_state == ST_BUSY);
      if (hit_cmd && state == ST_IDLE)
      begin
        cmd <= next_cmd;
      end
      for (j = 0; j < 4; j = j + 1)
      begin
        if (hit_fg && lane_be[j])
        begin
          fg_colour[j*8 +: 8] <= lane_data[j*8 +: 8];
        end
        if (hit_bg && lane_be[j])
        begin
          bg_colour[j*8 +: 8] <= lane_data[j*8 +: 8];
        end
      end
    end
  end

  // Field decode registered from the stored command
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      background_source_select_o <= 2'h0;
      foreground_source_select_o <= 2'h0;
      function_code_o            <= 4'h0;
      rectangle_block_transfer_o <= 1'b0;
      inverting_block_transfer_o <= 1'b0;
      area_fill_block_transfer_o <= 1'b0;
      draw_and_step_o            <= 1'b0;
      line_draw_o                <= 1'b0;
      step_read_o                <= 1'b0;
      fn_reserved_o              <= 1'b0;
      source_map_o               <= 4'h0;
      dest_map_o                 <= 4'h0;
      pattern_map_o              <= 4'h0;
      pattern_fixed_o            <= 1'b0;
      pattern_from_source_o      <= 1'b0;
      scissor_map_mode_o         <= 2'h0;
      draw_style_o               <= 2'h0;
      x_direction_bit_o          <= 1'b0;
      y_direction_bit_o          <= 1'b0;
      major_axis_bit_o           <= 1'b0;
    end
    else
    begin
      background_source_select_o <= cmd[`POCD_BS_MSB -: 2];
      foreground_source_select_o <= cmd[`POCD_FS_MSB -: 2];
      function_code_o            <= cmd[`POCD_FN_MSB -: 4];
      rectangle_block_transfer_o <=
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_BLT);
      inverting_block_transfer_o <=
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_INV_BLT);
      area_fill_block_transfer_o <=
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_FILL_BLT);
      draw_and_step_o <=
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_DS_READ) ||
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_DS_WRITE);
      line_draw_o <=
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_LINE_READ) ||
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_LINE_WRITE);
      step_read_o <=
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_DS_READ) ||
        (cmd[`POCD_FN_MSB -: 4] == `POCD_FN_LINE_READ);
      fn_reserved_o <=
        (cmd[`POCD_FN_MSB -: 4] < `POCD_FN_DS_READ) ||
        (cmd[`POCD_FN_MSB -: 4] == 4'h6) ||
        (cmd[`POCD_FN_MSB -: 4] == 4'h7) ||
        (cmd[`POCD_FN_MSB -: 4] > `POCD_FN_FILL_BLT);
      source_map_o          <= cmd[`POCD_SRC_MSB -: 4];
      dest_map_o            <= cmd[`POCD_DST_MSB -: 4];
      pattern_map_o         <= cmd[`POCD_PAT_MSB -: 4];
      pattern_fixed_o       <=
        (cmd[`POCD_PAT_MSB -: 4] == `POCD_PAT_FIXED_FG);
      pattern_from_source_o <=
        (cmd[`POCD_PAT_MSB -: 4] == `POCD_PAT_FROM_SRC);
      scissor_map_mode_o    <= cmd[`POCD_MSK_MSB -: 2];
      draw_style_o          <= cmd[`POCD_DM_MSB -: 2];
      x_direction_bit_o     <= cmd[`POCD_DX_BIT];
      y_direction_bit_o     <= cmd[`POCD_DY_BIT];
      major_axis_bit_o      <= cmd[`POCD_DZ_BIT];
    end
  end

  // Effective pattern pixel for the current pixel
  assign pattern_eff_o = pattern_fixed_o ? 1'b1 :
                         pattern_from_source_o ? source_nonzero_i :
                         pattern_pixel_i;

  always @*
  begin
    depth_mask = {PIX_W{1'b0}};
    for (k = 0; k < PIX_W; k = k + 1)
    begin
      if (k < dest_depth_i)
      begin
        depth_mask[k] = 1'b1;
      end
    end
  end

  // Mix source: colour registers trimmed to destination depth, or the untrimmed source pixel when source map is selected
  always @*
  begin
    colour_sel = {PIX_W{1'b0}};
    if (pattern_eff_o)
    begin
      if (foreground_source_select_o == `POCD_SRC_MAP)
      begin
        colour_sel = source_pixel_i;
      end
      else
      begin
        colour_sel = fg_colour[PIX_W-1:0] & depth_mask;
      end
    end
    else
    begin
      if (background_source_select_o == `POCD_SRC_MAP)
      begin
        colour_sel = source_pixel_i;
      end
      else
      begin
        colour_sel = bg_colour[PIX_W-1:0] & depth_mask;
      end
    end
  end

  assign mix_source_o = colour_sel;

endmodule // pocd_decoder
`default_nettype wire

// *** sim/pocd_decoder_properties.sv ***
`default_nettype none
module pocd_decoder_properties #(parameter PIX_W = 32) (
  input wire logic        clk_i, nrst_i, big_endian_i, wr_i, op_done_i,
  input wire logic        source_nonzero_i, wr_ready_o, op_start_o, busy_o,
  input wire logic [6:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0]  be_i, function_code_o, source_map_o, dest_map_o,
  input wire logic [3:0]  pattern_map_o,
  input wire logic [1:0]  background_source_select_o,
  input wire logic [1:0]  foreground_source_select_o,
  input wire logic [1:0]  scissor_map_mode_o, draw_style_o,
  input wire logic        rectangle_block_transfer_o, pattern_fixed_o,
  input wire logic        inverting_block_transfer_o, pattern_eff_o,
  input wire logic        area_fill_block_transfer_o, pattern_from_source_o,
  input wire logic        x_direction_bit_o, y_direction_bit_o, major_axis_bit_o
);
  logic [31:0] cmd_w, fld_w;
  logic        b3_en, step_fn, take_cmd;
  assign cmd_w = big_endian_i ? {wdata_i[7:0], wdata_i[15:8], wdata_i[23:16],
    wdata_i[31:24]} : wdata_i;
  assign b3_en    = big_endian_i ? be_i[0] : be_i[3];
  assign step_fn  = cmd_w[27:24] inside {[4'h2:4'h5]};
  assign take_cmd = wr_i && addr_i == 7'h7C && wr_ready_o;
  assign fld_w = {background_source_select_o, foreground_source_select_o,
    function_code_o, source_map_o, dest_map_o, pattern_map_o, 4'h0,
    scissor_map_mode_o, draw_style_o, 1'b0, x_direction_bit_o,
    y_direction_bit_o, major_axis_bit_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence full_cmd_s;
    take_cmd && be_i == 4'hF;
  endsequence
  sequence fields_out_s;
    ##2 fld_w == $past(cmd_w, 2);
  endsequence
  cmd_start_a:
    assert property (take_cmd && b3_en && !step_fn |=> op_start_o && busy_o)
    else $error("command write did not start");
  step_hold_a:
    assert property (take_cmd && step_fn |=> !op_start_o)
    else $error("step code started on command write");
  step_launch_a:
    assert property (wr_i && addr_i == 7'h2C && wr_ready_o &&
      function_code_o inside {[4'h2:4'h5]} |=> op_start_o)
    else $error("steps write did not start");
  start_cause_a:
    assert property (op_start_o |-> $past(wr_i) &&
      $past(addr_i) inside {7'h7C, 7'h2C})
    else $error("start without a write");
  busy_track_a:
    assert property (busy_o |=> busy_o != $past(op_done_i))
    else $error("busy does not follow done");
  fields_frozen_a:
    assert property (busy_o && $past(busy_o, 2) |-> $stable(fld_w))
    else $error("fields changed during operation");
  ready_idle_a:
    assert property (wr_ready_o != busy_o)
    else $error("ready not the inverse of busy");
  field_decode_a:
    assert property (full_cmd_s |-> fields_out_s)
    else $error("decoded fields differ from written word");
  blt_decode_a:
    assert property (rectangle_block_transfer_o == (function_code_o == 4'h8)
      && inverting_block_transfer_o == (function_code_o == 4'h9)
      && area_fill_block_transfer_o == (function_code_o == 4'hA))
    else $error("block transfer decode wrong");
  pattern_fixed_a:
    assert property (pattern_fixed_o == (pattern_map_o == 4'h8) &&
      (!pattern_fixed_o || pattern_eff_o))
    else $error("fixed pattern wrong");
  pattern_source_a:
    assert property (pattern_from_source_o |-> pattern_eff_o == source_nonzero_i)
    else $error("source pattern wrong");
endmodule // pocd_decoder_properties
bind pocd_decoder pocd_decoder_properties #(.PIX_W(PIX_W)) u_props (.*);
`default_nettype wire

// *** sim/pocd_host_model.sv ***
`default_nettype none
// Host side of the register bus: one posted write per call
module pocd_host_model (
  input  wire logic        clk_i,
  output var  logic        wr_o,
  output var  logic [6:0]  addr_o,
  output var  logic [31:0] wdata_o,
  output var  logic [3:0]  be_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    wr_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 32'h00000000;
    be_o = 4'h0;
  end
  // Callers send zero in unused bits, no reserved code, byte 3 last
  task automatic wr(input logic [6:0] a, input logic [31:0] d,
    input logic [3:0] b);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    be_o = b;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    be_o = 4'h0;
  endtask
endmodule // pocd_host_model
`default_nettype wire

// *** sim/pixel_op_command_decoder_test.sv ***
`default_nettype none
module pixel_op_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, nrst_i = 0, big_endian_i = 0, op_done_i = 0;
  logic pattern_pixel_i = 0, source_nonzero_i = 0;
  logic [5:0] dest_depth_i = 6'h04;
  logic [31:0] source_pixel_i = 32'h0000005A, wdata_i, mix_source_o;
  logic wr_i, wr_ready_o, op_start_o, busy_o;
  logic [6:0] addr_i;
  logic [3:0] be_i, function_code_o, source_map_o, dest_map_o, pattern_map_o;
  logic [1:0] background_source_select_o, foreground_source_select_o;
  logic [1:0] scissor_map_mode_o, draw_style_o;
  logic rectangle_block_transfer_o, inverting_block_transfer_o;
  logic area_fill_block_transfer_o, draw_and_step_o, line_draw_o, step_read_o;
  logic fn_reserved_o, pattern_fixed_o, pattern_from_source_o, pattern_eff_o;
  logic x_direction_bit_o, y_direction_bit_o, major_axis_bit_o;
  int bad_count = 0, num_checks = 0, cyc = 0;
  pocd_decoder #(.PIX_W(32)) uut (.*);
  pocd_host_model host (.clk_i(clk_i), .wr_o(wr_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .be_o(be_i));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      $display("FAIL %0t timeout", $time);
      stop_test;
    end
  end
  task chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [31:0] flds;
    return {background_source_select_o, foreground_source_select_o,
      function_code_o, source_map_o, dest_map_o, pattern_map_o, 4'h0,
      scissor_map_mode_o, draw_style_o, 1'b0, x_direction_bit_o,
      y_direction_bit_o, major_axis_bit_o};
  endfunction
  task finish_op;
    op_done_i = 1;
    tick;
    op_done_i = 0;
    chk(busy_o, 0);
  endtask
  task t_word;
    host.wr(7'h7C, 32'h88123065, 4'hF);
    chk({op_start_o, busy_o}, 2'b11);
    tick;
    chk(op_start_o, 0);
    chk(flds(), 32'h88123065);
    chk(rectangle_block_transfer_o, 1);
    chk(fn_reserved_o, 0);
    finish_op;
    $display("t_word done");
  endtask
  task t_bytes;
    host.wr(7'h58, 32'h12345678, 4'hF);
    host.wr(7'h5C, 32'h9ABCDEF3, 4'hF);
    for (int n = 0; n < 4; n++)
    begin
      host.wr(7'h7C, 32'h0A238007 & (32'hFF << (8 * n)), 4'h1 << n);
      chk(op_start_o, n == 3);
    end
    tick;
    chk(flds(), 32'h0A238007);
    chk(area_fill_block_transfer_o, 1);
    chk({pattern_eff_o, mix_source_o}, 33'h1_00000008);
    host.wr(7'h7C, 32'h88123065, 4'hF);
    chk({op_start_o, wr_ready_o}, 2'b00);
    tick;
    chk(flds(), 32'h0A238007);
    finish_op;
    $display("t_bytes done");
  endtask
  task t_halves;
    big_endian_i = 1;
    host.wr(7'h7C, 32'hB2900000, 4'hC);
    chk(op_start_o, 0);
    host.wr(7'h7C, 32'h00003129, 4'h3);
    chk(op_start_o, 1);
    tick;
    chk(flds(), 32'h293190B2);
    chk(inverting_block_transfer_o, 1);
    chk({pattern_eff_o, mix_source_o}, 33'h0_00000003);
    source_nonzero_i = 1;
    #1;
    chk({pattern_eff_o, mix_source_o}, 33'h1_0000005A);
    source_nonzero_i = 0;
    finish_op;
    big_endian_i = 0;
    $display("t_halves done");
  endtask
  task t_step;
    for (logic [3:0] f = 4'h2; f <= 4'h5; f++)
    begin
      host.wr(7'h7C, {4'h0, f, 24'h111000}, 4'hF);
      chk(op_start_o, 0);
      host.wr(7'h2C, 32'h00000000, 4'hF);
      chk(op_start_o, 1);
      tick;
      chk({draw_and_step_o, line_draw_o, step_read_o},
        {!f[0], f[0], f < 4'h4});
      finish_op;
    end
    $display("t_step done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    #1 nrst_i = 1;
    t_word;
    t_bytes;
    t_halves;
    t_step;
    stop_test;
  end
endmodule // pixel_op_command_decoder_test
`default_nettype wire
